// >>> core/dec_map.svh
// Purpose: register offsets, field positions and reset values of the raw/status bank
// Assumes: 8-bit registers on the two-wire control bus
// Notes: status bytes are read only
`ifndef DEC_MAP_SVH
`define DEC_MAP_SVH

`define DEC_SUB_GAIN 8'h18
`define DEC_SUB_OFFSET 8'h19
`define DEC_SUB_STAT1 8'h1E
`define DEC_SUB_STAT2 8'h1F

`define DEC_GAIN_RST 8'h80
`define DEC_OFFSET_RST 8'h80
`define DEC_GAIN_NOM 8'h80
`define DEC_OFFSET_ZERO 8'h80

`define DEC_S1_HUNL 6
`define DEC_S1_SLOW 5
`define DEC_S1_GMAX 4
`define DEC_S1_GMIN 3
`define DEC_S1_WPEAK 2
`define DEC_S1_STD 1:0

`define DEC_S2_ILACE 7
`define DEC_S2_HVUNL 6
`define DEC_S2_FID 5
`define DEC_S2_STRIPE4 3
`define DEC_S2_STRIPE 2
`define DEC_S2_PROT 1
`define DEC_S2_READY 0

`define DEC_BYTE_BITS 4'h8
`define DEC_GAIN_SHIFT 7
`define DEC_RAW_BIAS 11'h080
`define DEC_RAW_MAX 8'hFF

`endif

// >>> core/dec_pkg.sv
// Purpose: types shared by the raw/status register bank
// Assumes: status inputs come from decoder logic on the same clock
// Notes: none
package dec_pkg;

	typedef struct packed {
		logic horiz_freq_unlocked;
		logic vert_unlocked;
		logic slow_time_constant_on;
		logic luma_gain_at_max;
		logic luma_gain_at_min;
		logic white_peak_loop_on;
		logic [1:0] detected_color_standard;
		logic interlace_detected;
		logic field_rate_is_60hz;
		logic four_line_stripe_detected;
		logic color_stripe_detected;
		logic copy_protected_source;
		logic all_loops_locked;
	} status_in_t;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} i2c_state_t;

	typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_DATA} phase_t;

endpackage

// >>> core/raw_scale.sv
// Purpose: gain and offset applied to raw video samples
// Assumes: gain code 128 is unity, offset code 0x80 adds nothing
// Notes: result clamped to 0..255, one cycle latency
`timescale 1ns/1ps
`include "dec_map.svh"

module raw_scale (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] sample_i,
	input wire logic valid_i,
	input wire logic [7:0] gain_i,
	input wire logic [7:0] offset_i,
	output logic [7:0] sample_o,
	output logic valid_o
);
	logic [15:0] prod;
	logic [10:0] sum;
	logic [7:0] sample_reg, sample_next;
	logic valid_reg, valid_next;

	always_comb begin
		prod = {8'h00, sample_i} * {8'h00, gain_i};
		sum = {2'h0, prod[15:`DEC_GAIN_SHIFT]} + {3'h0, offset_i} - `DEC_RAW_BIAS;
		sample_next = sample_reg;
		valid_next = valid_i;
		if (valid_i) begin
			// saturate rather than wrap: a wrapped sample shows as a bright speck
			if (sum[10]) begin
				sample_next = 8'h00;
			end else if (sum[9:8] != 2'h0) begin
				sample_next = `DEC_RAW_MAX;
			end else begin
				sample_next = sum[7:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sample_reg <= 8'h00;
			valid_reg <= 1'b0;
		end else begin
			sample_reg <= sample_next;
			valid_reg <= valid_next;
		end
	end

	assign sample_o = sample_reg;
	assign valid_o = valid_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	property p_gain_off;
		valid_i && gain_i == 8'h00 && offset_i == `DEC_OFFSET_ZERO |=> valid_o && sample_o == 8'h00;
	endproperty
	a_gain_off: assert property (p_gain_off) else $error("gain zero did not mute");

	property p_gain_nom;
		valid_i && gain_i == `DEC_GAIN_NOM && offset_i == `DEC_OFFSET_ZERO
			|=> sample_o == $past(sample_i);
	endproperty
	a_gain_nom: assert property (p_gain_nom) else $error("nominal gain changed sample");

	property p_offset;
		valid_i && gain_i == `DEC_GAIN_NOM && sample_i == 8'h80 |=> sample_o == $past(offset_i);
	endproperty
	a_offset: assert property (p_offset) else $error("offset not offset-binary");

endmodule

// >>> core/raw_status_bank.sv
// Purpose: raw gain/offset registers and decoder status bytes on the control bus
// Assumes: SCL/SDA are open-drain pins; STATUS_I is on REF_CLK_I
// Notes: subaddress auto-increments; bus rate well below REF_CLK_I/8
//
// Behaviour
// - gain code scales raw data linearly; 128 nominal, 255 double, 0 off
// - offset code is offset-binary; 0x80 adds nothing, 0x00 minus 128
// - first status bit 6 is one while horizontal loop unlocked
// - first status bit 5 is one while slow time constant active
// - first status bits 4 and 3 flag luminance gain at max and min
// - first status bit 2 is one while white peak loop active
// - first status byte read only; bits 1:0 give detected color standard
// - second status bit 7 is one for interlaced video
// - second status bit 6 is zero only when both loops locked
// - second status bit 5 reads zero for 50 Hz, one for 60 Hz
// - second status bit 3 flags four-line color stripe burst
// - second status bit 2 flags color stripe burst of any type
// - second status byte read only; bit 1 flags copy-protected source
// - second status bit 0 is one only when all loops locked
`timescale 1ns/1ps
`include "dec_map.svh"

module raw_status_bank #(
	parameter logic [6:0] DEV_ADDR = 7'h21
) (
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire dec_pkg::status_in_t STATUS_I,
	input wire logic [7:0] RAW_SAMPLE_I,
	input wire logic RAW_VALID_I,
	output logic [7:0] RAW_SAMPLE_O,
	output logic RAW_VALID_O
);
	logic [1:0] scl_ff, sda_ff;
	logic scl_d, sda_d;
	logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
	dec_pkg::i2c_state_t st_reg, st_next;
	dec_pkg::phase_t ph_reg, ph_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] sub_reg, sub_next;
	logic rd_reg, rd_next;
	logic oe_reg, oe_next;
	logic [7:0] gain_reg, gain_next;
	logic [7:0] off_reg, off_next;
	logic [7:0] stat1_reg, stat1_next;
	logic [7:0] stat2_reg, stat2_next;
	logic [7:0] rd_byte;
	logic wr_stb;
	logic hv_unl;

	// pins are asynchronous to REF_CLK_I
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_ff <= {scl_ff[0], SCL_I};
			sda_ff <= {sda_ff[0], SDA_I};
			scl_d <= scl_ff[1];
			sda_d <= sda_ff[1];
		end
	end

	always_comb begin
		scl_s = scl_ff[1];
		sda_s = sda_ff[1];
		scl_rise = scl_s && !scl_d;
		scl_fall = !scl_s && scl_d;
		start_c = scl_s && scl_d && sda_d && !sda_s;
		stop_c = scl_s && scl_d && !sda_d && sda_s;
	end

	// status snapshot every cycle; reserved bits read zero
	always_comb begin
		hv_unl = STATUS_I.horiz_freq_unlocked || STATUS_I.vert_unlocked;
		stat1_next = 8'h00;
		stat1_next[`DEC_S1_HUNL] = STATUS_I.horiz_freq_unlocked;
		stat1_next[`DEC_S1_SLOW] = STATUS_I.slow_time_constant_on;
		stat1_next[`DEC_S1_GMAX] = STATUS_I.luma_gain_at_max;
		stat1_next[`DEC_S1_GMIN] = STATUS_I.luma_gain_at_min;
		stat1_next[`DEC_S1_WPEAK] = STATUS_I.white_peak_loop_on;
		stat1_next[`DEC_S1_STD] = STATUS_I.detected_color_standard;
		stat2_next = 8'h00;
		stat2_next[`DEC_S2_ILACE] = STATUS_I.interlace_detected;
		stat2_next[`DEC_S2_HVUNL] = hv_unl;
		stat2_next[`DEC_S2_FID] = STATUS_I.field_rate_is_60hz;
		stat2_next[`DEC_S2_STRIPE4] = STATUS_I.four_line_stripe_detected;
		stat2_next[`DEC_S2_STRIPE] = STATUS_I.color_stripe_detected;
		stat2_next[`DEC_S2_PROT] = STATUS_I.copy_protected_source;
		stat2_next[`DEC_S2_READY] = STATUS_I.all_loops_locked && !hv_unl;
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			stat1_reg <= 8'h00;
			stat2_reg <= 8'h00;
		end else begin
			stat1_reg <= stat1_next;
			stat2_reg <= stat2_next;
		end
	end

	always_comb begin
		unique case (sub_reg)
			`DEC_SUB_GAIN: rd_byte = gain_reg;
			`DEC_SUB_OFFSET: rd_byte = off_reg;
			`DEC_SUB_STAT1: rd_byte = stat1_reg;
			`DEC_SUB_STAT2: rd_byte = stat2_reg;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		ph_next = ph_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		sub_next = sub_reg;
		rd_next = rd_reg;
		oe_next = oe_reg;
		gain_next = gain_reg;
		off_next = off_reg;
		wr_stb = 1'b0;
		if (stop_c) begin
			st_next = dec_pkg::ST_IDLE;
			oe_next = 1'b0;
		end else if (start_c) begin
			// repeated start keeps the subaddress for a following read
			st_next = dec_pkg::ST_RX;
			ph_next = dec_pkg::PH_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end else begin
			unique case (st_reg)
				dec_pkg::ST_IDLE: begin
					oe_next = 1'b0;
				end
				dec_pkg::ST_RX: begin
					if (scl_rise && cnt_reg != `DEC_BYTE_BITS) begin
						sh_next = {sh_reg[6:0], sda_s};
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == `DEC_BYTE_BITS) begin
						cnt_next = 4'h0;
						st_next = dec_pkg::ST_ACK;
						oe_next = 1'b1;
						unique case (ph_reg)
							dec_pkg::PH_ADDR: begin
								if (sh_reg[7:1] != DEV_ADDR) begin
									st_next = dec_pkg::ST_IDLE;
									oe_next = 1'b0;
								end else begin
									rd_next = sh_reg[0];
									ph_next = dec_pkg::PH_SUB;
								end
							end
							dec_pkg::PH_SUB: begin
								sub_next = sh_reg;
								ph_next = dec_pkg::PH_DATA;
							end
							dec_pkg::PH_DATA: begin
								wr_stb = 1'b1;
								sub_next = sub_reg + 8'h01;
								// status subaddresses fall through: write acked, no effect
								if (sub_reg == `DEC_SUB_GAIN) begin
									gain_next = sh_reg;
								end else if (sub_reg == `DEC_SUB_OFFSET) begin
									off_next = sh_reg;
								end
							end
						endcase
					end
				end
				dec_pkg::ST_ACK: begin
					if (scl_fall) begin
						if (rd_reg) begin
							sh_next = rd_byte;
							sub_next = sub_reg + 8'h01;
							oe_next = !rd_byte[7];
							cnt_next = 4'h1;
							st_next = dec_pkg::ST_TX;
						end else begin
							oe_next = 1'b0;
							st_next = dec_pkg::ST_RX;
						end
					end
				end
				dec_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt_reg == `DEC_BYTE_BITS) begin
							oe_next = 1'b0;
							st_next = dec_pkg::ST_TXACK;
						end else begin
							oe_next = !sh_reg[6];
							sh_next = {sh_reg[6:0], 1'b0};
							cnt_next = cnt_reg + 4'h1;
						end
					end
				end
				dec_pkg::ST_TXACK: begin
					if (scl_rise) begin
						st_next = sda_s ? dec_pkg::ST_IDLE : dec_pkg::ST_ACK;
					end
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_reg <= dec_pkg::ST_IDLE;
			ph_reg <= dec_pkg::PH_ADDR;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			sub_reg <= 8'h00;
			rd_reg <= 1'b0;
			oe_reg <= 1'b0;
			gain_reg <= `DEC_GAIN_RST;
			off_reg <= `DEC_OFFSET_RST;
		end else begin
			st_reg <= st_next;
			ph_reg <= ph_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			sub_reg <= sub_next;
			rd_reg <= rd_next;
			oe_reg <= oe_next;
			gain_reg <= gain_next;
			off_reg <= off_next;
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			SDA_O <= 1'b0;
		end else begin
			SDA_O <= 1'b0;
		end
	end

	assign SDA_OE_O = oe_reg;

	raw_scale raw_scale_inst (
		.clk_i(REF_CLK_I),
		.nrst_i(NRST_I),
		.sample_i(RAW_SAMPLE_I),
		.valid_i(RAW_VALID_I),
		.gain_i(gain_reg),
		.offset_i(off_reg),
		.sample_o(RAW_SAMPLE_O),
		.valid_o(RAW_VALID_O)
	);

	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);

	property p_gain_wr;
		wr_stb && sub_reg == `DEC_SUB_GAIN |=> gain_reg == $past(sh_reg) && $stable(off_reg);
	endproperty
	a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");

	property p_ro_wr;
		wr_stb && (sub_reg == `DEC_SUB_STAT1 || sub_reg == `DEC_SUB_STAT2)
			|=> $stable(gain_reg) && $stable(off_reg);
	endproperty
	a_ro_wr: assert property (p_ro_wr) else $error("status write had an effect");

	property p_hunl;
		##1 stat1_reg[`DEC_S1_HUNL] == $past(STATUS_I.horiz_freq_unlocked);
	endproperty
	a_hunl: assert property (p_hunl) else $error("horizontal unlock not shown");

	property p_wpeak;
		##1 stat1_reg[`DEC_S1_WPEAK] == $past(STATUS_I.white_peak_loop_on)
			&& stat1_reg[`DEC_S1_SLOW] == $past(STATUS_I.slow_time_constant_on);
	endproperty
	a_wpeak: assert property (p_wpeak) else $error("white peak bits wrong");

	property p_limits;
		##1 stat1_reg[`DEC_S1_GMAX] == $past(STATUS_I.luma_gain_at_max)
			&& stat1_reg[`DEC_S1_GMIN] == $past(STATUS_I.luma_gain_at_min);
	endproperty
	a_limits: assert property (p_limits) else $error("gain limit bits wrong");

	property p_std;
		##1 stat1_reg[`DEC_S1_STD] == $past(STATUS_I.detected_color_standard) && !stat1_reg[7];
	endproperty
	a_std: assert property (p_std) else $error("color standard wrong");

	property p_hv;
		##1 stat2_reg[`DEC_S2_HVUNL]
			== ($past(STATUS_I.vert_unlocked) || $past(STATUS_I.horiz_freq_unlocked));
	endproperty
	a_hv: assert property (p_hv) else $error("vertical unlock not shown");

	property p_ready;
		##1 stat2_reg[`DEC_S2_READY]
			== ($past(STATUS_I.all_loops_locked) && !stat2_reg[`DEC_S2_HVUNL]);
	endproperty
	a_ready: assert property (p_ready) else $error("ready while unlocked");

	property p_stat2;
		##1 stat2_reg[`DEC_S2_ILACE] == $past(STATUS_I.interlace_detected)
			&& stat2_reg[`DEC_S2_FID] == $past(STATUS_I.field_rate_is_60hz)
			&& stat2_reg[`DEC_S2_STRIPE4] == $past(STATUS_I.four_line_stripe_detected)
			&& stat2_reg[`DEC_S2_STRIPE] == $past(STATUS_I.color_stripe_detected)
			&& stat2_reg[`DEC_S2_PROT] == $past(STATUS_I.copy_protected_source) && !stat2_reg[4];
	endproperty
	a_stat2: assert property (p_stat2) else $error("second status byte wrong");

	c_gain_wr: cover property (wr_stb && sub_reg == `DEC_SUB_GAIN);
	c_stat_rd: cover property (st_reg == dec_pkg::ST_ACK && rd_reg && scl_fall
		&& sub_reg == `DEC_SUB_STAT2);
	c_nack: cover property (st_reg == dec_pkg::ST_TXACK && scl_rise && sda_s);

endmodule

// >>> tb/i2c_host.sv
// Purpose: host controller model on the two-wire control bus
// Assumes: SDA is open drain with a pull-up resolved by the bench
// Notes: SCL is high HALF reference cycles per data bit and low twice that; no clock stretching
`timescale 1ns/1ps

module i2c_host #(
	parameter logic [6:0] DEV = 7'h21,
	parameter int HALF = 5
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic hold();
		repeat (HALF) @(posedge clk_i);
	endtask
	// doubles as repeated start: data released before the clock rises
	task automatic start();
		sda_pull_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_pull_o <= 1'b1;
		hold();
		scl_o <= 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_pull_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_pull_o <= 1'b0;
		hold();
	endtask
	// sample at the end of the high phase, when the device holds steady
	task automatic bit_x(input logic b, output logic r);
		sda_pull_o <= ~b;
		hold();
		scl_o <= 1'b1;
		hold();
		r = sda_i;
		scl_o <= 1'b0;
		hold();
	endtask
	task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(rel, ack);
	endtask
	task automatic wr(input logic [7:0] sub, input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		xfer({DEV, 1'b0}, 1'b1, q, a0);
		xfer(sub, 1'b1, q, a1);
		xfer(d, 1'b1, q, a2);
		stop();
		nak = a0 | a1 | a2;
	endtask
	// single byte read ends with a not-acknowledge, then stop
	task automatic rd(input logic [7:0] sub, output logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		start();
		xfer({DEV, 1'b0}, 1'b1, q, a0);
		xfer(sub, 1'b1, q, a1);
		start();
		xfer({DEV, 1'b1}, 1'b1, q, a2);
		xfer(8'hFF, 1'b1, d, a3);
		stop();
		nak = a0 | a1 | a2;
	endtask
endmodule

// >>> tb/decoder_raw_gain_offset_status_bench.sv
// Purpose: self-checking bench for the raw gain/offset and status bank
// Assumes: host model drives the bus, bench resolves the open-drain SDA wire
// Notes: random stimulus from a fixed-seed shift register
`timescale 1ns/1ps

module decoder_raw_gain_offset_status_bench;
	logic clk, nrst, scl, sda, sda_pull, sda_oe, sda_drv, raw_valid, raw_valid_o, nak;
	logic [7:0] raw_in, raw_out, rdat, gain, offs, q;
	logic [7:0] tab [3] = '{8'h00, 8'h80, 8'hFF};
	logic [31:0] lfsr;
	dec_pkg::status_in_t status;
	int mismatches;
	int cmp_count;
	assign sda = ~((sda_oe & ~sda_drv) | sda_pull);
	raw_status_bank raw_status_bank_inst (.REF_CLK_I(clk), .NRST_I(nrst), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_drv), .SDA_OE_O(sda_oe), .STATUS_I(status),
		.RAW_SAMPLE_I(raw_in), .RAW_VALID_I(raw_valid), .RAW_SAMPLE_O(raw_out),
		.RAW_VALID_O(raw_valid_o));
	i2c_host i2c_host_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));
	function automatic logic [31:0] step(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	function automatic logic [7:0] scale(input logic [7:0] s, input logic [7:0] g,
		input logic [7:0] o);
		int v;
		v = ((int'(s) * int'(g)) >>> 7) + int'(o) - 128;
		if (v < 0) v = 0;
		if (v > 255) v = 255;
		return v[7:0];
	endfunction
	function automatic logic [7:0] s1(input dec_pkg::status_in_t s);
		return {1'b0, s.horiz_freq_unlocked, s.slow_time_constant_on, s.luma_gain_at_max,
			s.luma_gain_at_min, s.white_peak_loop_on, s.detected_color_standard};
	endfunction
	function automatic logic [7:0] s2(input dec_pkg::status_in_t s);
		logic unl;
		unl = s.horiz_freq_unlocked | s.vert_unlocked;
		return {s.interlace_detected, unl, s.field_rate_is_60hz, 1'b0,
			s.four_line_stripe_detected, s.color_stripe_detected, s.copy_protected_source,
			s.all_loops_locked & ~unl};
	endfunction
	task automatic wrap_up();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_chk(input logic [7:0] sub, input logic [7:0] d);
		i2c_host_inst.wr(sub, d, nak);
		cmp({7'h00, nak}, 8'h00);
	endtask
	task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
		i2c_host_inst.rd(sub, rdat, nak);
		cmp({7'h00, nak}, 8'h00);
		cmp(rdat, exp);
		cmp({7'h00, sda_drv}, 8'h00);
	endtask
	task automatic raw_chk(input logic [7:0] s);
		@(posedge clk);
		raw_in <= s;
		raw_valid <= 1'b1;
		@(posedge clk);
		raw_valid <= 1'b0;
		@(negedge clk);
		cmp(raw_out, scale(s, gain, offs));
		cmp({7'h00, raw_valid_o}, 8'h01);
		// output must hold once valid drops
		@(negedge clk);
		cmp(raw_out, scale(s, gain, offs));
		cmp({7'h00, raw_valid_o}, 8'h00);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard: the run never needs this many cycles
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
	initial begin
		nrst = 1'b0;
		raw_in = 8'h00;
		raw_valid = 1'b0;
		status = '0;
		lfsr = 32'hB7210351;
		mismatches = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(8'h18, 8'h80);
		rd_chk(8'h19, 8'h80);
		for (int i = 0; i < 12; i++) begin
			lfsr = step(lfsr);
			gain = (i < 9) ? tab[i % 3] : lfsr[7:0];
			offs = (i < 9) ? tab[i / 3] : lfsr[15:8];
			wr_chk(8'h18, gain);
			wr_chk(8'h19, offs);
			rd_chk(8'h18, gain);
			raw_chk(8'h00);
			raw_chk(8'hFF);
			raw_chk(lfsr[23:16]);
			raw_chk(8'h80);
		end
		for (int i = 0; i < 14; i++) begin
			lfsr = step(lfsr);
			status <= (i == 0) ? dec_pkg::status_in_t'(14'h0000) :
				(i == 1) ? dec_pkg::status_in_t'(14'h3FFF) : dec_pkg::status_in_t'(lfsr[13:0]);
			repeat (3) @(posedge clk);
			if (i[0]) begin
				wr_chk(8'h1E, lfsr[31:24]);
				wr_chk(8'h1F, ~lfsr[31:24]);
			end
			rd_chk(8'h1E, s1(status));
			rd_chk(8'h1F, s2(status));
		end
		// two-byte read: master acknowledge and subaddress auto-increment
		i2c_host_inst.start();
		i2c_host_inst.xfer({7'h21, 1'b0}, 1'b1, q, nak);
		i2c_host_inst.xfer(8'h1E, 1'b1, q, nak);
		i2c_host_inst.start();
		i2c_host_inst.xfer({7'h21, 1'b1}, 1'b1, q, nak);
		i2c_host_inst.xfer(8'hFF, 1'b0, rdat, nak);
		cmp(rdat, s1(status));
		i2c_host_inst.xfer(8'hFF, 1'b1, rdat, nak);
		i2c_host_inst.stop();
		cmp(rdat, s2(status));
		wr_chk(8'h20, 8'h55);
		rd_chk(8'h20, 8'h00);
		i2c_host_inst.start();
		i2c_host_inst.xfer({7'h22, 1'b0}, 1'b1, q, nak);
		i2c_host_inst.stop();
		cmp({7'h00, nak}, 8'h01);
		rd_chk(8'h19, offs);
		wrap_up();
	end
endmodule
